// ### uic_pkg.sv
package uic_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_DIV_LOW = 32'h5000_1100;
  localparam logic [31:0] ADDR_IER_DLH = 32'h5000_1104;
  localparam logic [31:0] ADDR_IIR_FCR = 32'h5000_1108;
  localparam logic [31:0] ADDR_LINE_CTRL = 32'h5000_110C;
  localparam logic [31:0] ADDR_FLOW_CTRL = 32'h5000_1110;
  localparam logic [31:0] ADDR_EVT_STAT = 32'h5000_1180;
  localparam logic [31:0] ADDR_EVT_CLR = 32'h5000_1184;
  localparam logic [31:0] ADDR_EVT_EN = 32'h5000_1188;
  // interrupt enable bit positions
  localparam int IER_PROG_EMPTY_IRQ_MODE_EN = 7;
  localparam int IER_MODEM = 3;
  localparam int IER_LINE = 2;
  localparam int IER_TX_HOLD_EMPTY_FLAG = 1;
  localparam int IER_RXAV = 0;
  localparam logic [7:0] IER_MASK = 8'h8F;
  // fifo control write fields
  localparam int FCR_RT_LSB = 6;
  localparam int FCR_TET_LSB = 4;
  localparam int FCR_DMA_SIGNAL_MODE = 3;
  localparam int FCR_TXRST = 2;
  localparam int FCR_RXRST = 1;
  localparam int FCR_FIFOEN = 0;
  localparam int LCR_DIVISOR_ACCESS_SELECT = 7;
  localparam int FLOW_AFCE = 1;
  localparam int FLOW_RTS = 0;
  // identification codes
  localparam logic [3:0] ID_MODEM = 4'h0;
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_TX_HOLD_EMPTY_FLAG = 4'h2;
  localparam logic [3:0] ID_RXAV = 4'h4;
  localparam logic [3:0] ID_LINE = 4'h6;
  localparam logic [3:0] ID_BUSY = 4'h7;
  localparam logic [3:0] ID_TIMEOUT = 4'hC;
  // fifo depth and trigger levels, in characters
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] RX_TRIG_ONE = 5'h01;
  localparam logic [4:0] RX_TRIG_QTR = 5'h04;
  localparam logic [4:0] RX_TRIG_HALF = 5'h08;
  localparam logic [4:0] RX_TRIG_TWOLESS = 5'h0E;
  localparam logic [4:0] TX_TRIG_EMPTY = 5'h00;
  localparam logic [4:0] TX_TRIG_TWO = 5'h02;
  localparam logic [4:0] TX_TRIG_QTR = 5'h04;
  localparam logic [4:0] TX_TRIG_HALF = 5'h08;
  localparam int NUM_SRC = 6;
  localparam logic [15:0] RST_DIVISOR = 16'h0000;
endpackage

// ### uic_irq_fifo_control.sv
`timescale 1ns/1ps
// Contract
// - ier bit 7 enables programmable empty mode
// - ier bit 3 gates modem status, fourth
// - ier bit 2 gates line status, highest
// - ier bit 1 gates transmit empty, third
// - ier bit 0 gates rx data, timeout
// - divisor access maps address to divisor high
// - ident read, fifo control write, separate
// - ident bits 7:6 show fifo enable
// - ident bits 3:0 give pending code
// - rx trigger sets interrupt, dma level
// - auto flow drops rts at trigger
// - tx empty trigger sets interrupt, dma
// - fcr bit 3 picks dma mode
// - fcr bit 2 flushes tx, self-clearing
// - fcr bit 1 flushes rx, self-clearing
// - line control bit 7 selects divisor
// - baud is clock over sixteen divisor
// - fcr bit 0 enables fifos
module uic_irq_fifo_control (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [4:0] RX_LEVEL,
  input wire logic [4:0] TX_LEVEL,
  input wire logic RX_LINE_ERR,
  input wire logic CHAR_TIMEOUT,
  input wire logic MODEM_CHANGE,
  input wire logic BUSY_DETECT,
  output logic FIFO_ENABLE,
  output logic TX_FIFO_FLUSH,
  output logic RX_FIFO_FLUSH,
  output logic [15:0] DIVISOR,
  output logic BAUD16_TICK,
  output logic RTS_N,
  output logic DMA_TX_REQ_N,
  output logic DMA_RX_REQ_N,
  output logic IRQ
);
  import uic_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [7:0] ier_q;
  logic [7:0] lcr_q;
  logic [1:0] flow_q;
  logic [15:0] div_q;
  logic fifo_en_q;
  logic [1:0] rt_q;
  logic [1:0] tet_q;
  logic dma_signal_mode_q;
  logic tx_flush_q;
  logic rx_flush_q;
  logic [15:0] baud_cnt_q;
  logic baud_tick_q;
  logic rts_stop_q;
  logic rts_n_q;
  logic rx_dma_q;
  logic tx_dma_q;
  logic dma_rx_n_q;
  logic dma_tx_n_q;
  logic [NUM_SRC-1:0] src_q;
  logic [NUM_SRC-1:0] stat_q;
  logic [NUM_SRC-1:0] evt_en_q;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////
  // apb decode; one wait state so that every output is a flop
  wire setup_acc = PSEL & PENABLE & ~pready_q;
  wire acc = PSEL & PENABLE & pready_q;
  wire wr = acc & PWRITE;
  wire divisor_access_select = lcr_q[LCR_DIVISOR_ACCESS_SELECT];
  wire sel_dll = PADDR == ADDR_DIV_LOW;
  wire sel_ier = PADDR == ADDR_IER_DLH;
  wire sel_iir = PADDR == ADDR_IIR_FCR;
  wire sel_lcr = PADDR == ADDR_LINE_CTRL;
  wire sel_flow = PADDR == ADDR_FLOW_CTRL;
  wire sel_stat = PADDR == ADDR_EVT_STAT;
  wire sel_clr = PADDR == ADDR_EVT_CLR;
  wire sel_een = PADDR == ADDR_EVT_EN;
  // low divisor shares its address with the data path, not held here
  wire hit = (sel_dll & divisor_access_select) | sel_ier | sel_iir | sel_lcr | sel_flow |
             sel_stat | sel_clr | sel_een;
  wire wr_ier = wr & sel_ier & ~divisor_access_select;
  wire wr_dlh = wr & sel_ier & divisor_access_select;
  wire wr_dll = wr & sel_dll & divisor_access_select;
  wire wr_fcr = wr & sel_iir;
  wire [7:0] wbyte = PWDATA[7:0];

  ////////////////////////////////////////////////////////////////////////
  // source qualification
  wire [4:0] rx_trig = (rt_q == 2'h0) ? RX_TRIG_ONE :
                       (rt_q == 2'h1) ? RX_TRIG_QTR :
                       (rt_q == 2'h2) ? RX_TRIG_HALF : RX_TRIG_TWOLESS;
  wire [4:0] tx_trig = (tet_q == 2'h0) ? TX_TRIG_EMPTY :
                       (tet_q == 2'h1) ? TX_TRIG_TWO :
                       (tet_q == 2'h2) ? TX_TRIG_QTR : TX_TRIG_HALF;
  wire rx_nonempty = RX_LEVEL != 5'h00;
  wire rx_at_trig = RX_LEVEL >= rx_trig;
  // without fifos a single holding register stands in
  wire rx_avail = fifo_en_q ? rx_at_trig : rx_nonempty;
  wire prog_empty_irq_mode_en_act = ier_q[IER_PROG_EMPTY_IRQ_MODE_EN] & fifo_en_q;
  wire tx_hold_empty_flag_src = prog_empty_irq_mode_en_act ? (TX_LEVEL <= tx_trig) :
                  (TX_LEVEL == 5'h00);
  // order: line, rx data, timeout, tx_hold_empty_flag, modem, busy
  wire [NUM_SRC-1:0] src = {BUSY_DETECT, MODEM_CHANGE, tx_hold_empty_flag_src,
                            CHAR_TIMEOUT, rx_avail, RX_LINE_ERR};
  // busy detect has no enable bit and is always considered
  wire [NUM_SRC-1:0] src_en = {1'b1, ier_q[IER_MODEM], ier_q[IER_TX_HOLD_EMPTY_FLAG],
                               ier_q[IER_RXAV] & fifo_en_q,
                               ier_q[IER_RXAV], ier_q[IER_LINE]};
  wire [NUM_SRC-1:0] pend = src & src_en;
  wire [3:0] pend_code = pend[0] ? ID_LINE :
                         pend[1] ? ID_RXAV :
                         pend[2] ? ID_TIMEOUT :
                         pend[3] ? ID_TX_HOLD_EMPTY_FLAG :
                         pend[4] ? ID_MODEM :
                         pend[5] ? ID_BUSY : ID_NONE;
  wire [7:0] ident = {fifo_en_q, fifo_en_q, 2'h0, pend_code};

  ////////////////////////////////////////////////////////////////////////
  // read mux
  wire [15:0] rd_val =
    (sel_dll & divisor_access_select) ? {8'h00, div_q[7:0]} :
    (sel_ier & divisor_access_select) ? {8'h00, div_q[15:8]} :
    sel_ier ? {8'h00, ier_q} :
    sel_iir ? {8'h00, ident} :
    sel_lcr ? {8'h00, lcr_q} :
    sel_flow ? {14'h0000, flow_q} :
    sel_stat ? {10'h000, stat_q} :
    sel_een ? {10'h000, evt_en_q} : 16'h0000;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_acc;
      pslverr_q <= setup_acc & ~hit;
      if (setup_acc) begin
        prdata_q <= {16'h0000, rd_val};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ier_q <= 8'h00;
      lcr_q <= 8'h00;
      flow_q <= 2'h0;
      div_q <= RST_DIVISOR;
      evt_en_q <= '0;
    end else begin
      if (wr_ier) begin
        ier_q <= wbyte & IER_MASK;
      end
      if (wr_dlh) begin
        div_q[15:8] <= wbyte;
      end
      if (wr_dll) begin
        div_q[7:0] <= wbyte;
      end
      if (wr & sel_lcr) begin
        lcr_q <= wbyte;
      end
      if (wr & sel_flow) begin
        flow_q <= PWDATA[1:0];
      end
      if (wr & sel_een) begin
        evt_en_q <= PWDATA[NUM_SRC-1:0];
      end
    end
  end

  // flush bits are held for one cycle only; a read of this address returns the ident, not them
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      fifo_en_q <= 1'b0;
      rt_q <= 2'h0;
      tet_q <= 2'h0;
      dma_signal_mode_q <= 1'b0;
      tx_flush_q <= 1'b0;
      rx_flush_q <= 1'b0;
    end else begin
      tx_flush_q <= wr_fcr & wbyte[FCR_TXRST];
      rx_flush_q <= wr_fcr & wbyte[FCR_RXRST];
      if (wr_fcr) begin
        fifo_en_q <= wbyte[FCR_FIFOEN];
        rt_q <= wbyte[FCR_RT_LSB +: 2];
        tet_q <= wbyte[FCR_TET_LSB +: 2];
        dma_signal_mode_q <= wbyte[FCR_DMA_SIGNAL_MODE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sixteen-times baud enable; a zero divisor stops it
  wire div_zero = div_q == 16'h0000;
  wire baud_wrap = baud_cnt_q >= div_q - 16'h0001;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      baud_cnt_q <= 16'h0000;
      baud_tick_q <= 1'b0;
    end else if (div_zero) begin
      baud_cnt_q <= 16'h0000;
      baud_tick_q <= 1'b0;
    end else begin
      baud_tick_q <= baud_wrap;
      baud_cnt_q <= baud_wrap ? 16'h0000 : baud_cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flow control and dma requests; hold terms give hysteresis
  wire afce_act = flow_q[FLOW_AFCE] & fifo_en_q;
  wire rts_stop = rx_at_trig | (rts_stop_q & rx_nonempty);
  wire rx_dma = (dma_signal_mode_q & fifo_en_q) ?
                (rx_at_trig | (rx_dma_q & rx_nonempty)) : rx_nonempty;
  wire tx_dma = (dma_signal_mode_q & fifo_en_q) ?
                ((TX_LEVEL <= tx_trig) |
                 (tx_dma_q & (TX_LEVEL < FIFO_DEPTH))) :
                (TX_LEVEL == 5'h00);

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rts_stop_q <= 1'b0;
      rts_n_q <= 1'b1;
      rx_dma_q <= 1'b0;
      tx_dma_q <= 1'b0;
      dma_rx_n_q <= 1'b1;
      dma_tx_n_q <= 1'b1;
    end else begin
      rts_stop_q <= rts_stop;
      rts_n_q <= ~flow_q[FLOW_RTS] | (afce_act & rts_stop);
      rx_dma_q <= rx_dma;
      tx_dma_q <= tx_dma;
      dma_rx_n_q <= ~rx_dma;
      dma_tx_n_q <= ~tx_dma;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky source events; a set in the clearing cycle wins
  wire clr_wr = wr & sel_clr;
  wire [NUM_SRC-1:0] evt_set = src & ~src_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_evt
      always_ff @(posedge CLOCK) begin
        if (SRST) begin
          stat_q[gi] <= 1'b0;
          src_q[gi] <= 1'b0;
        end else begin
          src_q[gi] <= src[gi];
          stat_q[gi] <= evt_set[gi] |
                        (stat_q[gi] & ~(clr_wr & PWDATA[gi]));
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|pend) | (|(stat_q & evt_en_q));
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign FIFO_ENABLE = fifo_en_q;
  assign TX_FIFO_FLUSH = tx_flush_q;
  assign RX_FIFO_FLUSH = rx_flush_q;
  assign DIVISOR = div_q;
  assign BAUD16_TICK = baud_tick_q;
  assign RTS_N = rts_n_q;
  assign DMA_TX_REQ_N = dma_tx_n_q;
  assign DMA_RX_REQ_N = dma_rx_n_q;
  assign IRQ = irq_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  sequence s_fcr_wr(int b);
    wr_fcr && wbyte[b];
  endsequence

  a_prog_empty_irq_mode_en_tx_hold_empty_flag: assert property (
    (prog_empty_irq_mode_en_act && TX_LEVEL > tx_trig) |-> !tx_hold_empty_flag_src)
    else $error("programmable empty mode ignored");
  a_modem_gate: assert property (
    !ier_q[IER_MODEM] && !ier_q[IER_TX_HOLD_EMPTY_FLAG] && !pend[5] && !pend[3]
    |-> pend_code != ID_MODEM)
    else $error("modem code without enable");
  a_line_first: assert property (
    (ier_q[IER_LINE] && RX_LINE_ERR) |-> pend_code == ID_LINE)
    else $error("line status not highest");
  a_tx_hold_empty_flag_third: assert property (
    (pend[3] && !pend[0] && !pend[1] && !pend[2])
    |-> pend_code == ID_TX_HOLD_EMPTY_FLAG)
    else $error("tx_hold_empty_flag code wrong");
  a_timeout_fifo: assert property (
    !fifo_en_q |-> pend_code != ID_TIMEOUT)
    else $error("timeout without fifos");
  a_dlh_write: assert property (
    wr_dlh |=> div_q[15:8] == $past(wbyte) && $stable(ier_q))
    else $error("divisor high write wrong");
  a_fifo_flag: assert property (
    (setup_acc && sel_iir && !PWRITE)
    |=> prdata_q[7:6] == {2{$past(fifo_en_q)}})
    else $error("fifo flag bits wrong");
  a_rts_stop: assert property (
    (afce_act && rx_at_trig) |=> RTS_N)
    else $error("rts not dropped at trigger");
  a_dma_mode0: assert property (
    (!dma_signal_mode_q && rx_nonempty) |=> !DMA_RX_REQ_N)
    else $error("mode 0 rx request missing");
  // pulse stands in the cycle right after the write edge
  a_tx_flush: assert property (
    s_fcr_wr(FCR_TXRST) ##1 !wr_fcr |-> TX_FIFO_FLUSH ##1 !TX_FIFO_FLUSH)
    else $error("tx flush not one pulse");
  a_rx_flush: assert property (
    s_fcr_wr(FCR_RXRST) ##1 !wr_fcr |-> RX_FIFO_FLUSH ##1 !RX_FIFO_FLUSH)
    else $error("rx flush not one pulse");
  a_irq_level: assert property (
    (|pend) |=> IRQ)
    else $error("irq low with pending source");
  a_none_code: assert property (
    (pend == '0) |-> pend_code == ID_NONE)
    else $error("code without pending source");
endmodule

// ### uic_far_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// far side: fifo fill counts as the data path would report them
module uic_far_model (
  input wire logic clk,
  input wire logic rx_flush,
  input wire logic tx_flush,
  input wire logic load,
  input wire logic [4:0] rx_want,
  input wire logic [4:0] tx_want,
  output logic [4:0] rx_level,
  output logic [4:0] tx_level
);
  initial begin
    rx_level = 5'h00;
    tx_level = 5'h00;
  end
  // a flush beats a load, the fifo is then reported empty
  always @(posedge clk) begin
    rx_level <= rx_flush ? 5'h00 : (load ? rx_want : rx_level);
    tx_level <= tx_flush ? 5'h00 : (load ? tx_want : tx_level);
  end
endmodule

// ### uic_irq_fifo_control_tb.sv
`timescale 1ns/1ps
module uic_irq_fifo_control_tb;
  import uic_pkg::*;
  logic CLOCK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er, load;
  logic [31:0] PADDR, PWDATA, PRDATA, rd;
  logic [4:0] RX_LEVEL, TX_LEVEL, rx_want, tx_want;
  logic RX_LINE_ERR, CHAR_TIMEOUT, MODEM_CHANGE, BUSY_DETECT;
  logic FIFO_ENABLE, TX_FIFO_FLUSH, RX_FIFO_FLUSH, BAUD16_TICK, RTS_N;
  logic DMA_TX_REQ_N, DMA_RX_REQ_N, IRQ;
  logic [15:0] DIVISOR;
  int error_cnt = 0;
  int checks_done = 0;
  int txf_n = 0;
  int rxf_n = 0;
  int tick_n = 0;
  uic_irq_fifo_control dut (
    .CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_LEVEL(RX_LEVEL),
    .TX_LEVEL(TX_LEVEL), .RX_LINE_ERR(RX_LINE_ERR),
    .CHAR_TIMEOUT(CHAR_TIMEOUT), .MODEM_CHANGE(MODEM_CHANGE),
    .BUSY_DETECT(BUSY_DETECT), .FIFO_ENABLE(FIFO_ENABLE),
    .TX_FIFO_FLUSH(TX_FIFO_FLUSH), .RX_FIFO_FLUSH(RX_FIFO_FLUSH),
    .DIVISOR(DIVISOR), .BAUD16_TICK(BAUD16_TICK), .RTS_N(RTS_N),
    .DMA_TX_REQ_N(DMA_TX_REQ_N), .DMA_RX_REQ_N(DMA_RX_REQ_N), .IRQ(IRQ)
  );
  uic_far_model far (
    .clk(CLOCK), .rx_flush(RX_FIFO_FLUSH), .tx_flush(TX_FIFO_FLUSH),
    .load(load), .rx_want(rx_want), .tx_want(tx_want),
    .rx_level(RX_LEVEL), .tx_level(TX_LEVEL)
  );
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  // pulse widths are judged by how many edges saw them high
  always @(posedge CLOCK) begin
    if (TX_FIFO_FLUSH === 1'b1) txf_n++;
    if (RX_FIFO_FLUSH === 1'b1) rxf_n++;
    if (BAUD16_TICK === 1'b1) tick_n++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    // no cap here: only the watchdog ends a wait
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1);
    chk("ready wait", 32'h2, 32'(n));
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [31:0] a,
                     input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // fifos on: bits 7:6 read as ones
  task automatic idc(input logic [3:0] c);
    rdc("ident", ADDR_IIR_FCR, {24'h000000, 4'hC, c});
  endtask
  // order: line error, timeout, modem change, busy
  task automatic src(input logic [3:0] v);
    @(posedge CLOCK);
    RX_LINE_ERR <= v[3];
    CHAR_TIMEOUT <= v[2];
    MODEM_CHANGE <= v[1];
    BUSY_DETECT <= v[0];
  endtask
  task automatic lvl(input logic [4:0] r, input logic [4:0] t);
    @(posedge CLOCK);
    rx_want <= r;
    tx_want <= t;
    load <= 1'b1;
    @(posedge CLOCK);
    load <= 1'b0;
  endtask
  // outputs are registered, so let two edges land before looking
  task automatic wt;
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc("enables", ADDR_IER_DLH, 32'h0);
    rdc("ident", ADDR_IIR_FCR, 32'h01);
    chk("irq", 32'h0, 32'(IRQ));
    chk("divisor", 32'h0, 32'(DIVISOR));
    wr(ADDR_IER_DLH, 32'hFF);
    rdc("enables", ADDR_IER_DLH, 32'h8F);
  endtask
  task automatic t_prio;
    logic [3:0] s [7] = '{4'hF, 4'h7, 4'h7, 4'h3, 4'h3, 4'h1, 4'h0};
    logic [4:0] r [7] = '{5'h01, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
    logic [4:0] t [7] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h05, 5'h05, 5'h05};
    logic [3:0] c [7] = '{4'h6, 4'h4, 4'hC, 4'h2, 4'h0, 4'h7, 4'h1};
    wr(ADDR_IIR_FCR, 32'h01);
    wr(ADDR_IER_DLH, 32'h0F);
    for (int k = 0; k < 7; k++) begin
      src(s[k]);
      lvl(r[k], t[k]);
      wt;
      idc(c[k]);
      chk("irq", 32'(c[k] != ID_NONE), 32'(IRQ));
    end
    wr(ADDR_IER_DLH, 32'h00);
    src(4'h8);
    wt;
    idc(ID_NONE);
    chk("irq", 32'h0, 32'(IRQ));
    src(4'h0);
  endtask
  task automatic t_trig;
    logic [4:0] rt [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
    logic [4:0] te [4] = '{5'h00, 5'h02, 5'h04, 5'h08};
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_IER_DLH, 32'h01);
      wr(ADDR_IIR_FCR, {24'h000000, k[1:0], 6'h01});
      lvl(rt[k] - 5'h01, 5'h05);
      wt;
      idc(ID_NONE);
      lvl(rt[k], 5'h05);
      wt;
      idc(ID_RXAV);
      wr(ADDR_IER_DLH, 32'h82);
      wr(ADDR_IIR_FCR, {24'h000000, 2'h0, k[1:0], 4'h1});
      lvl(5'h00, te[k] + 5'h01);
      wt;
      idc(ID_NONE);
      lvl(5'h00, te[k]);
      wt;
      idc(ID_TX_HOLD_EMPTY_FLAG);
    end
    wr(ADDR_IER_DLH, 32'h02);
    lvl(5'h00, 5'h02);
    wt;
    idc(ID_NONE);
  endtask
  task automatic t_dma_rts;
    logic [4:0] r [4] = '{5'h03, 5'h04, 5'h02, 5'h00};
    logic [3:0] e = 4'h6;
    wr(ADDR_IER_DLH, 32'h00);
    lvl(5'h00, 5'h05);
    wr(ADDR_IIR_FCR, 32'h49);
    lvl(5'h02, 5'h05);
    wt;
    chk("dma rx", 32'h1, 32'(DMA_RX_REQ_N));
    wr(ADDR_IIR_FCR, 32'h41);
    wt;
    chk("dma rx", 32'h0, 32'(DMA_RX_REQ_N));
    lvl(5'h00, 5'h05);
    wr(ADDR_FLOW_CTRL, 32'h03);
    for (int k = 0; k < 4; k++) begin
      lvl(r[k], 5'h05);
      wt;
      chk("rts", 32'(e[k]), 32'(RTS_N));
    end
    wr(ADDR_FLOW_CTRL, 32'h00);
    // mode 1 tx request: from tet level down, held until full
    wr(ADDR_IIR_FCR, 32'h59);
    wt;
    chk("dma tx", 32'h1, 32'(DMA_TX_REQ_N));
    lvl(5'h00, 5'h02);
    wt;
    chk("dma tx", 32'h0, 32'(DMA_TX_REQ_N));
    lvl(5'h00, 5'h05);
    wt;
    chk("dma tx", 32'h0, 32'(DMA_TX_REQ_N));
    wr(ADDR_IIR_FCR, 32'h41);
    wt;
    chk("dma tx", 32'h1, 32'(DMA_TX_REQ_N));
  endtask
  task automatic t_flush;
    int a;
    int b;
    lvl(5'h05, 5'h05);
    wt;
    a = txf_n;
    b = rxf_n;
    wr(ADDR_IIR_FCR, 32'h87);
    wt;
    chk("tx flush", 32'h1, 32'(txf_n - a));
    chk("rx flush", 32'h1, 32'(rxf_n - b));
    chk("fifo on", 32'h1, 32'(FIFO_ENABLE));
    rdc("ident", ADDR_IIR_FCR, 32'hC1);
    wr(ADDR_IIR_FCR, 32'h00);
    wt;
    chk("fifo on", 32'h0, 32'(FIFO_ENABLE));
    rdc("ident", ADDR_IIR_FCR, 32'h01);
  endtask
  task automatic t_div;
    int a;
    wr(ADDR_IER_DLH, 32'h8F);
    wr(ADDR_LINE_CTRL, 32'h80);
    wr(ADDR_IER_DLH, 32'hA5);
    wr(ADDR_DIV_LOW, 32'h5A);
    rdc("div high", ADDR_IER_DLH, 32'hA5);
    wt;
    chk("divisor", 32'h0000A55A, 32'(DIVISOR));
    wr(ADDR_IER_DLH, 32'h00);
    wr(ADDR_DIV_LOW, 32'h05);
    repeat (100) @(negedge CLOCK);
    a = tick_n;
    repeat (50) @(negedge CLOCK);
    chk("ticks", 32'h0000000A, 32'(tick_n - a));
    wr(ADDR_LINE_CTRL, 32'h00);
    rdc("enables", ADDR_IER_DLH, 32'h8F);
    xfer(1'b0, ADDR_DIV_LOW, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    wr(ADDR_IER_DLH, 32'h00);
  endtask
  task automatic t_evt;
    lvl(5'h00, 5'h05);
    wr(ADDR_EVT_CLR, 32'h3F);
    rdc("status", ADDR_EVT_STAT, 32'h0);
    wr(ADDR_EVT_EN, 32'h10);
    src(4'h2);
    wt;
    rdc("status", ADDR_EVT_STAT, 32'h10);
    chk("irq", 32'h1, 32'(IRQ));
    wr(ADDR_EVT_EN, 32'h0);
    wt;
    chk("irq", 32'h0, 32'(IRQ));
    wr(ADDR_EVT_EN, 32'h10);
    wr(ADDR_EVT_CLR, 32'h10);
    wt;
    rdc("status", ADDR_EVT_STAT, 32'h0);
    chk("irq", 32'h0, 32'(IRQ));
    xfer(1'b0, 32'h500011F0, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // whole run is under a thousand cycles, so this margin is generous
  initial begin
    repeat (20000) @(posedge CLOCK);
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    conclude;
  end
  initial begin
    SRST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 32'h0;
    PWDATA = 32'h0;
    rx_want = 5'h00;
    tx_want = 5'h00;
    load = 1'b0;
    RX_LINE_ERR = 1'b0;
    CHAR_TIMEOUT = 1'b0;
    MODEM_CHANGE = 1'b0;
    BUSY_DETECT = 1'b0;
    repeat (5) @(posedge CLOCK);
    SRST <= 1'b0;
    t_reset;
    t_prio;
    t_trig;
    t_dma_rts;
    t_flush;
    t_div;
    t_evt;
    conclude;
  end
endmodule
